// File: logic/interrupt_and_power_mode_ctrl.sv
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "irq_power_defs.svh"

module interrupt_and_power_mode_ctrl (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [9:0] sourceRequest,
    input wire logic instrDone,
    output logic irqValid,
    output logic [3:0] irqIndex,
    output logic coreSuspend,
    output logic clockHalt,
    output logic analogPowerDown,
    output logic peripheralClockRun
);
    logic [7:0] sourceEnable_r;
    logic [7:0] extSourceEnable_r;
    logic [7:0] basePriority_r;
    logic [7:0] extPriority_r;
    logic [7:0] extControl_r;
    logic [1:0] powerControl_r;
    logic [1:0] powerControl_nxt;
    logic [1:0] activeLevels_r;
    logic [1:0] activeLevels_nxt;
    logic irqValid_r;
    logic [3:0] irqIndex_r;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    irq_power_pkg::power_state_t state_r;
    irq_power_pkg::power_state_t state_nxt;
    logic hreadyout_r;
    logic coreSuspend_r;
    logic clockHalt_r;
    logic analogPowerDown_r;
    logic peripheralClockRun_r;

    logic wrStrobe;
    logic rdPhase;
    logic [7:0] regAddr;

    ahb_reg_slave u_bus (
        .clock(clock),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .wrStrobe(wrStrobe),
        .rdPhase(rdPhase),
        .regAddr(regAddr)
    );

    // Sources in natural order, index 0 served first within a level.
    wire [9:0] enableVec = {
        extControl_r[`WDOG_ENABLE_BIT],
        extSourceEnable_r[1],
        extSourceEnable_r[0],
        sourceEnable_r[6],
        sourceEnable_r[5],
        sourceEnable_r[4],
        sourceEnable_r[3],
        sourceEnable_r[2],
        sourceEnable_r[1],
        sourceEnable_r[0]
    };
    wire [9:0] priorityVec = {
        extPriority_r[`WDOG_PRIORITY_BIT],
        extPriority_r[1],
        extPriority_r[0],
        basePriority_r[6],
        basePriority_r[5],
        basePriority_r[4],
        basePriority_r[3],
        basePriority_r[2],
        basePriority_r[1],
        basePriority_r[0]
    };
    wire globalEnable = sourceEnable_r[`GLOBAL_ENABLE_BIT];
    wire [9:0] enabledReq = sourceRequest & enableVec & {10{globalEnable}};
    wire [9:0] highReq = enabledReq & priorityVec;
    wire [9:0] lowReq = enabledReq & ~priorityVec;

    logic highFound;
    logic [3:0] highIndex;
    logic lowFound;
    logic [3:0] lowIndex;

    irq_priority_pick u_pick_high (
        .pending(highReq),
        .found(highFound),
        .index(highIndex)
    );
    irq_priority_pick u_pick_low (
        .pending(lowReq),
        .found(lowFound),
        .index(lowIndex)
    );

    wire inStop = (state_r == irq_power_pkg::PWR_STOP);
    wire inIdle = (state_r == irq_power_pkg::PWR_IDLE);
    // High may be taken unless a high routine runs; low only when nothing runs.
    wire highOk = highFound & ~activeLevels_r[1];
    wire lowOk = lowFound & ~highFound & (activeLevels_r == 2'b00);
    wire offerValid = (highOk | lowOk) & ~inStop;
    wire [3:0] offerIndex = highOk ? highIndex : lowIndex;

    // Next-state decodes feed the registered power outputs.
    wire nextInStop = (state_nxt == irq_power_pkg::PWR_STOP);
    wire nextInRun = (state_nxt == irq_power_pkg::PWR_RUN);
    // A read costs one wait state, since hrdata is loaded in the first data-phase cycle and stands in the second.
    wire readTake = hsel & hready & htrans[1] & ~hwrite;

    wire wrSrcEn = wrStrobe & (regAddr == `ADDR_SOURCE_ENABLE);
    wire wrExtEn = wrStrobe & (regAddr == `ADDR_EXT_SOURCE_ENABLE);
    wire wrBasePri = wrStrobe & (regAddr == `ADDR_BASE_PRIORITY);
    wire wrExtPri = wrStrobe & (regAddr == `ADDR_EXT_PRIORITY);
    wire wrExtCtl = wrStrobe & (regAddr == `ADDR_EXT_CONTROL);
    wire wrPower = wrStrobe & (regAddr == `ADDR_POWER_CONTROL);
    wire wrService = wrStrobe & (regAddr == `ADDR_SERVICE);
    wire serviceTake = wrService & hwdata[`SERVICE_TAKE_BIT] & irqValid_r;
    wire serviceDone = wrService & hwdata[`SERVICE_DONE_BIT];
    wire takeHigh = serviceTake & priorityVec[irqIndex_r];

    // Power-control bits: set by software, idle cleared by an enabled request.
    always_comb begin
        powerControl_nxt = powerControl_r;
        if (wrPower) begin
            powerControl_nxt = hwdata[1:0];
        end
        if (inStop) begin
            powerControl_nxt[`STOP_BIT] = 1'b1;
        end
        if (inIdle && enabledReq != 10'h000) begin
            powerControl_nxt[`IDLE_BIT] = 1'b0;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            irq_power_pkg::PWR_RUN: begin
                if (instrDone && powerControl_r[`STOP_BIT]) begin
                    state_nxt = irq_power_pkg::PWR_STOP;
                end else if (instrDone && powerControl_r[`IDLE_BIT]) begin
                    state_nxt = irq_power_pkg::PWR_IDLE;
                end
            end
            irq_power_pkg::PWR_IDLE: begin
                if (enabledReq != 10'h000) begin
                    state_nxt = irq_power_pkg::PWR_RUN;
                end else if (powerControl_r[`STOP_BIT]) begin
                    state_nxt = irq_power_pkg::PWR_STOP;
                end
            end
            irq_power_pkg::PWR_STOP: begin
                state_nxt = irq_power_pkg::PWR_STOP;
            end
            default: begin
                state_nxt = irq_power_pkg::PWR_RUN;
            end
        endcase
    end

    // A take and a return may meet in one write; the new level wins.
    always_comb begin
        activeLevels_nxt = activeLevels_r;
        if (serviceDone) begin
            if (activeLevels_r[1]) begin
                activeLevels_nxt[1] = 1'b0;
            end else begin
                activeLevels_nxt[0] = 1'b0;
            end
        end
        if (serviceTake) begin
            if (takeHigh) begin
                activeLevels_nxt[1] = 1'b1;
            end else begin
                activeLevels_nxt[0] = 1'b1;
            end
        end
    end

    wire [31:0] statusWord = {20'h0_0000, activeLevels_r, state_r, irqValid_r, 3'b000, irqIndex_r};

    always_comb begin
        hrdata_nxt = 32'h0000_0000;
        if (rdPhase) begin
            unique case (regAddr)
                `ADDR_SOURCE_ENABLE: hrdata_nxt = {24'h00_0000, sourceEnable_r};
                `ADDR_EXT_SOURCE_ENABLE: hrdata_nxt = {24'h00_0000, extSourceEnable_r};
                `ADDR_BASE_PRIORITY: hrdata_nxt = {24'h00_0000, basePriority_r};
                `ADDR_EXT_PRIORITY: hrdata_nxt = {24'h00_0000, extPriority_r};
                `ADDR_EXT_CONTROL: hrdata_nxt = {24'h00_0000, extControl_r};
                `ADDR_POWER_CONTROL: hrdata_nxt = {30'h000_0000, powerControl_r};
                `ADDR_STATUS: hrdata_nxt = statusWord;
                default: hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sourceEnable_r <= `RESET_BYTE;
            extSourceEnable_r <= `RESET_BYTE;
            basePriority_r <= `RESET_BYTE;
            extPriority_r <= `RESET_BYTE;
            extControl_r <= `RESET_BYTE;
        end else begin
            if (wrSrcEn) begin
                sourceEnable_r <= hwdata[7:0];
            end
            if (wrExtEn) begin
                extSourceEnable_r <= hwdata[7:0];
            end
            if (wrBasePri) begin
                basePriority_r <= hwdata[7:0];
            end
            if (wrExtPri) begin
                extPriority_r <= hwdata[7:0];
            end
            if (wrExtCtl) begin
                extControl_r <= hwdata[7:0];
            end
        end
    end

    // Reset is the only way out of stop and one way out of idle.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r <= irq_power_pkg::PWR_RUN;
            powerControl_r <= 2'b00;
            activeLevels_r <= 2'b00;
        end else begin
            state_r <= state_nxt;
            powerControl_r <= powerControl_nxt;
            activeLevels_r <= activeLevels_nxt;
        end
    end

    // The offer is registered, so the core sees a request one cycle after it arrives.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irqValid_r <= 1'b0;
            irqIndex_r <= 4'h0;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
        end else begin
            irqValid_r <= offerValid & ~serviceTake;
            irqIndex_r <= offerIndex;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= ~readTake;
        end
    end

    // The power outputs load from the next state, so they switch on the same edge as the state itself.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            coreSuspend_r <= 1'b0;
            clockHalt_r <= 1'b0;
            analogPowerDown_r <= 1'b0;
            peripheralClockRun_r <= 1'b1;
        end else begin
            coreSuspend_r <= ~nextInRun;
            clockHalt_r <= nextInStop;
            analogPowerDown_r <= nextInStop;
            peripheralClockRun_r <= ~nextInStop;
        end
    end

    // Registers keep their contents in idle since only the core is suspended.
    assign coreSuspend = coreSuspend_r;
    assign clockHalt = clockHalt_r;
    assign analogPowerDown = analogPowerDown_r;
    assign peripheralClockRun = peripheralClockRun_r;
    assign irqValid = irqValid_r;
    assign irqIndex = irqIndex_r;
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
endmodule

// File: logic/irq_power_defs.svh
`ifndef IRQ_POWER_DEFS_SVH
`define IRQ_POWER_DEFS_SVH

`define NUM_SOURCES 10
// Register byte addresses on the bus.
`define ADDR_SOURCE_ENABLE 8'h00
`define ADDR_EXT_SOURCE_ENABLE 8'h04
`define ADDR_BASE_PRIORITY 8'h08
`define ADDR_EXT_PRIORITY 8'h0C
`define ADDR_EXT_CONTROL 8'h10
`define ADDR_POWER_CONTROL 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_SERVICE 8'h1C
// Field positions.
`define GLOBAL_ENABLE_BIT 7
`define IDLE_BIT 0
`define STOP_BIT 1
`define WDOG_ENABLE_BIT 1
`define WDOG_PRIORITY_BIT 4
`define SERVICE_DONE_BIT 0
`define SERVICE_TAKE_BIT 1
// Reset values.
`define RESET_BYTE 8'h00

`endif

// File: logic/irq_power_pkg.sv
package irq_power_pkg;
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_STOP = 2'b11
    } power_state_t;

    typedef logic [9:0] source_vec_t;
endpackage

// File: logic/irq_priority_pick.sv
`timescale 1ns/10ps
// Picks the lowest-numbered pending source; index 0 is the first in natural order.
module irq_priority_pick (
    input wire logic [9:0] pending,
    output logic found,
    output logic [3:0] index
);
    logic [3:0] pick [0:10];
    logic [10:0] seen;

    assign seen[10] = 1'b0;
    assign pick[10] = 4'h0;

    genvar i;
    generate
        for (i = 0; i < 10; i = i + 1) begin : g_pick
            assign seen[i] = pending[i] | seen[i + 1];
            assign pick[i] = pending[i] ? 4'(i) : pick[i + 1];
        end
    endgenerate

    assign found = seen[0];
    assign index = pick[0];
endmodule

// File: logic/ahb_reg_slave.sv
`timescale 1ns/10ps
// AHB-Lite slave front end; turns an accepted address phase into a one-cycle data-phase strobe.
module ahb_reg_slave (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic wrStrobe,
    output logic rdPhase,
    output logic [7:0] regAddr
);
    logic wrPend_r;
    logic rdPend_r;
    logic [7:0] addr_r;
    wire takeAddr = hsel & hready & htrans[1];

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wrPend_r <= 1'b0;
            rdPend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wrPend_r <= takeAddr & hwrite;
            rdPend_r <= takeAddr & ~hwrite;
            if (takeAddr) begin
                addr_r <= haddr;
            end
        end
    end

    assign wrStrobe = wrPend_r;
    assign rdPhase = rdPend_r;
    assign regAddr = addr_r;
endmodule

// File: verification/irq_power_ctrl_sva.sv
`timescale 1ns/10ps
module irq_power_ctrl_sva (
    input wire logic clock,
    input wire logic reset,
    input wire logic [9:0] sourceRequest,
    input wire logic instrDone,
    input wire logic irqValid,
    input wire logic [3:0] irqIndex,
    input wire logic coreSuspend,
    input wire logic clockHalt,
    input wire logic analogPowerDown,
    input wire logic peripheralClockRun
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    stop_outputs_a: assert property (clockHalt |-> analogPowerDown && coreSuspend && !peripheralClockRun)
        else $error("stop outputs disagree");
    idle_clock_a: assert property (coreSuspend && !clockHalt |-> peripheralClockRun && !analogPowerDown)
        else $error("idle stopped the peripheral clock");
    stop_hold_a: assert property (clockHalt |=> clockHalt)
        else $error("stop left without reset");
    stop_refuse_a: assert property (clockHalt [*3] |-> !irqValid)
        else $error("request offered in stop");
    quiet_novalid_a: assert property ($past(sourceRequest) == 10'h000 |-> !irqValid)
        else $error("offer without any request");
    index_pending_a: assert property (irqValid |-> (($past(sourceRequest) >> irqIndex) & 10'h001) != 10'h000)
        else $error("offered source is not pending");
    idle_entry_a: assert property ($rose(coreSuspend) |-> $past(instrDone))
        else $error("suspend before instruction end");
    idle_wake_a: assert property ((coreSuspend && !clockHalt ##1 irqValid) |-> !coreSuspend)
        else $error("idle not ended by request");
    idle_cause_a: assert property ($fell(coreSuspend) |-> $past(sourceRequest) != 10'h000)
        else $error("idle ended without a request");
endmodule

bind interrupt_and_power_mode_ctrl irq_power_ctrl_sva chk (.clock, .reset, .sourceRequest, .instrDone, .irqValid,
    .irqIndex, .coreSuspend, .clockHalt, .analogPowerDown, .peripheralClockRun);

// File: verification/core_source_model.sv
`timescale 1ns/10ps
// Core and peripherals: an instruction ends every fourth clock unless the core is suspended.
module core_source_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic [9:0] wantReq,
    input wire logic coreSuspend,
    output logic [9:0] sourceRequest,
    output logic instrDone
);
    logic [1:0] phase_r;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_r <= 2'h0;
            sourceRequest <= 10'h000;
        end else begin
            phase_r <= coreSuspend ? 2'h0 : phase_r + 2'h1;
            sourceRequest <= wantReq;
        end
    end
    assign instrDone = (phase_r == 2'h3);
endmodule

// File: verification/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 50) begin @(posedge clock); n++; end \
    if (n >= 50) begin fail_count++; test_done(); end end
module testbench;
    logic clock, reset, hsel, hwrite, instrDone, irqValid, coreSuspend, clockHalt, analogPowerDown;
    logic peripheralClockRun, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, q;
    logic [9:0] wantReq, sourceRequest;
    logic [3:0] irqIndex;
    int fail_count, comparisons, n;

    interrupt_and_power_mode_ctrl dut (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .sourceRequest, .instrDone, .irqValid,
        .irqIndex, .coreSuspend, .clockHalt, .analogPowerDown, .peripheralClockRun);
    core_source_model partner (.clock, .reset, .wantReq, .coreSuspend, .sourceRequest, .instrDone);

    task automatic test_done;
        $display("mismatches=%0d compares=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Starts and ends just after a rising edge; read data is taken at the edge that ends the data phase.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        `WAIT(1'b0 || (n > 0 && hreadyout === 1'b1))
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        `WAIT(1'b0 || (n > 0 && hreadyout === 1'b1))
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic settle(input logic [9:0] r);
        wantReq <= r;
        repeat (3) @(posedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        reset = 1'b1;
        {hsel, hwrite, haddr, htrans, hwdata, wantReq} = '0;
        fail_count = 0;
        comparisons = 0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int a = 0; a <= 32; a += 4) begin
            xfer(1'b0, 8'(a), 32'h0000_0000);
            `CHK(q, 32'h0000_0000)
        end
        xfer(1'b1, 8'h00, 32'h0000_0002);
        settle(10'h002);
        `CHK(irqValid, 1'b0)
        xfer(1'b1, 8'h00, 32'h0000_0082);
        settle(10'h200);
        `CHK(irqValid, 1'b0)
        settle(10'h002);
        `CHK({irqValid, irqIndex}, 5'h11)
        xfer(1'b1, 8'h00, 32'h0000_00FF);
        xfer(1'b1, 8'h04, 32'h0000_0003);
        xfer(1'b1, 8'h10, 32'h0000_0002);
        xfer(1'b0, 8'h04, 32'h0000_0000);
        `CHK(q, 32'h0000_0003)
        for (int k = 0; k < 10; k++) begin
            settle(10'h3FF << k);
            `CHK({irqValid, irqIndex}, {1'b1, 4'(k)})
        end
        xfer(1'b1, 8'h0C, 32'h0000_0010);
        settle(10'h201);
        `CHK({irqValid, irqIndex}, 5'h19)
        xfer(1'b1, 8'h1C, 32'h0000_0002);
        settle(10'h001);
        `CHK(irqValid, 1'b0)
        xfer(1'b1, 8'h1C, 32'h0000_0001);
        settle(10'h001);
        `CHK({irqValid, irqIndex}, 5'h10)
        xfer(1'b1, 8'h1C, 32'h0000_0002);
        settle(10'h201);
        `CHK({irqValid, irqIndex}, 5'h19)
        xfer(1'b1, 8'h1C, 32'h0000_0002);
        xfer(1'b0, 8'h18, 32'h0000_0000);
        `CHK(q, 32'h0000_0C00)
        xfer(1'b1, 8'h1C, 32'h0000_0001);
        xfer(1'b1, 8'h1C, 32'h0000_0001);
        settle(10'h000);
        xfer(1'b1, 8'h14, 32'h0000_0001);
        `WAIT(coreSuspend === 1'b1)
        `CHK({peripheralClockRun, clockHalt}, 2'h2)
        wantReq <= 10'h001;
        `WAIT(coreSuspend === 1'b0)
        xfer(1'b0, 8'h14, 32'h0000_0000);
        `CHK(q[0], 1'b0)
        settle(10'h000);
        xfer(1'b1, 8'h14, 32'h0000_0002);
        `WAIT(clockHalt === 1'b1)
        `CHK({analogPowerDown, peripheralClockRun}, 2'h2)
        settle(10'h001);
        repeat (8) @(posedge clock);
        `CHK({clockHalt, irqValid}, 2'h2)
        xfer(1'b0, 8'h14, 32'h0000_0000);
        `CHK(q[1], 1'b1)
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        `CHK({clockHalt, coreSuspend}, 2'h0)
        test_done();
    end
endmodule
